/* File: core/tcps_top.sv */
// Pin-function select for register A of timer channels 4 and 5.
// Assumes the counter and compare pulses come from ref_clk logic;
// the pins arrive asynchronously and are synchronised here.
// Behaviour
// - Codes 0000-0011 are compare mode; 0001-0011 start the pin low, 0000 disables it.
// - Codes 0100-0111 are compare mode; 0101-0111 start the pin high, 0100 disables it.
// - In compare mode, low bits 01 drive the pin to 0 on each match.
// - In compare mode, low bits 10 drive the pin to 1 on each match.
// - In compare mode, low bits 11 invert the pin on each match.
// - Capture from the pin with low bits 00 takes the counter on a rising edge.
// - Capture from the pin with low bits 01 takes the counter on a falling edge.
// - Capture from the pin with bit 1 set takes the counter on both edges.
// - Channel 4 codes 1000-1011 use the channel 4 pin as capture source.
// - Channel 4 codes 11xx capture on every channel 3 register A match or capture.
// - Channel 5 ignores bit 2 in capture mode and always uses its own pin.
// - Channel 3 sourced capture happens in the cycle the channel 3 event occurs.
module tcps_top #(
    parameter int CNT_W = tcps_pkg::CNT_W_DEF
) (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic [tcps_pkg::ADDR_W-1:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [31:0] rdata,
    input wire logic [CNT_W-1:0] counter4,
    input wire logic [CNT_W-1:0] counter5,
    input wire logic ch4_match,
    input wire logic ch5_match,
    input wire logic ch3_reg_a_event,
    input wire logic ch4_timer_pin_a_in,
    output logic ch4_timer_pin_a_out,
    output logic ch4_timer_pin_a_oe,
    input wire logic ch5_timer_pin_a_in,
    output logic ch5_timer_pin_a_out,
    output logic ch5_timer_pin_a_oe,
    output logic ch4_capture,
    output logic ch5_capture
);
    logic [3:0] ch4_func_reg;
    logic [3:0] ch5_pin_control_reg;
    logic [2:0] sync4_reg;
    logic [2:0] sync5_reg;
    logic pin4_reg;
    logic pin5_reg;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    logic [CNT_W-1:0] ch4_general_reg_a;
    logic [CNT_W-1:0] ch5_general_reg_a;
    logic wr4;
    logic wr5;

    tcps_pin_if ctl4 ();
    tcps_pin_if ctl5 ();

    function automatic logic hit(input logic [tcps_pkg::ADDR_W-1:0] a,
                                 input logic [tcps_pkg::ADDR_W-1:0] ofs);
        hit = (a == ofs);
    endfunction

    assign wr4 = wr_en & hit(addr, tcps_pkg::OFS_CH4_FUNC);
    assign wr5 = wr_en & hit(addr, tcps_pkg::OFS_CH5_FUNC);

    // ------------------------------------------------------------
    // Function fields
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            ch4_func_reg <= tcps_pkg::FUNC_RESET;
            ch5_pin_control_reg <= tcps_pkg::FUNC_RESET;
        end else begin
            if (wr4) begin
                ch4_func_reg <= wdata[tcps_pkg::FUNC_W-1:0];
            end
            if (wr5) begin
                ch5_pin_control_reg <= wdata[tcps_pkg::FUNC_W-1:0];
            end
        end
    end

    // ------------------------------------------------------------
    // Pin synchronisers: change accepted when stages 2 and 3 agree
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            sync4_reg <= 3'h0;
            sync5_reg <= 3'h0;
            pin4_reg <= 1'b0;
            pin5_reg <= 1'b0;
        end else begin
            sync4_reg <= {sync4_reg[1:0], ch4_timer_pin_a_in};
            sync5_reg <= {sync5_reg[1:0], ch5_timer_pin_a_in};
            if (sync4_reg[1] == sync4_reg[2]) begin
                pin4_reg <= sync4_reg[2];
            end
            if (sync5_reg[1] == sync5_reg[2]) begin
                pin5_reg <= sync5_reg[2];
            end
        end
    end

    // ------------------------------------------------------------
    // Channel units
    // ------------------------------------------------------------
    // The written code takes effect one cycle after the write, so the
    // unit applies the initial level on the cycle after the strobe.
    logic wr4_dly_reg;
    logic wr5_dly_reg;
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            wr4_dly_reg <= 1'b0;
            wr5_dly_reg <= 1'b0;
        end else begin
            wr4_dly_reg <= wr4;
            wr5_dly_reg <= wr5;
        end
    end

    tcps_chan_a #(.CNT_W(CNT_W), .IS_CH4(1'b1)) u_ch4 (
        .ref_clk(ref_clk),
        .arst_n(arst_n),
        .func(ch4_func_reg),
        .func_wr(wr4_dly_reg),
        .counter(counter4),
        .compare_match(ch4_match),
        .pin_in(pin4_reg),
        .ch3_event(ch3_reg_a_event),
        .wr_data(wdata[CNT_W-1:0]),
        .reg_wr(wr_en & hit(addr, tcps_pkg::OFS_CH4_REG_A)),
        .ctl(ctl4),
        .reg_a_reg(ch4_general_reg_a),
        .pin_out_reg(ch4_timer_pin_a_out),
        .pin_oe_reg(ch4_timer_pin_a_oe),
        .capture_pulse_reg(ch4_capture)
    );

    tcps_chan_a #(.CNT_W(CNT_W), .IS_CH4(1'b0)) u_ch5 (
        .ref_clk(ref_clk),
        .arst_n(arst_n),
        .func(ch5_pin_control_reg),
        .func_wr(wr5_dly_reg),
        .counter(counter5),
        .compare_match(ch5_match),
        .pin_in(pin5_reg),
        .ch3_event(1'b0),
        .wr_data(wdata[CNT_W-1:0]),
        .reg_wr(wr_en & hit(addr, tcps_pkg::OFS_CH5_REG_A)),
        .ctl(ctl5),
        .reg_a_reg(ch5_general_reg_a),
        .pin_out_reg(ch5_timer_pin_a_out),
        .pin_oe_reg(ch5_timer_pin_a_oe),
        .capture_pulse_reg(ch5_capture)
    );

    // ------------------------------------------------------------
    // Read port; unmapped offsets read zero
    // ------------------------------------------------------------
    always_comb begin
        rdata_next = 32'h0000_0000;
        if (hit(addr, tcps_pkg::OFS_CH4_FUNC)) begin
            rdata_next[tcps_pkg::FUNC_W-1:0] = ch4_func_reg;
        end else if (hit(addr, tcps_pkg::OFS_CH5_FUNC)) begin
            rdata_next[tcps_pkg::FUNC_W-1:0] = ch5_pin_control_reg;
        end else if (hit(addr, tcps_pkg::OFS_CH4_REG_A)) begin
            rdata_next[CNT_W-1:0] = ch4_general_reg_a;
        end else if (hit(addr, tcps_pkg::OFS_CH5_REG_A)) begin
            rdata_next[CNT_W-1:0] = ch5_general_reg_a;
        end else if (hit(addr, tcps_pkg::OFS_STATUS)) begin
            rdata_next[tcps_pkg::ST_CH4_PIN] = ch4_timer_pin_a_out;
            rdata_next[tcps_pkg::ST_CH5_PIN] = ch5_timer_pin_a_out;
            rdata_next[tcps_pkg::ST_CH4_OE] = ch4_timer_pin_a_oe;
            rdata_next[tcps_pkg::ST_CH5_OE] = ch5_timer_pin_a_oe;
        end
    end

    // Data stands only in the cycle after the read strobe
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            rdata_reg <= 32'h0000_0000;
        end else if (rd_en) begin
            rdata_reg <= rdata_next;
        end else begin
            rdata_reg <= 32'h0000_0000;
        end
    end

    assign rdata = rdata_reg;
endmodule // tcps_top

/* File: core/tcps_pkg.sv */
// Package for the channel 4/5 register-A pin-function decoder.
// Assumes one 100 MHz clock and an asynchronous active-low reset.
package tcps_pkg;
    // ------------------------------------------------------------
    // Field layout
    // ------------------------------------------------------------
    localparam int FUNC_W = 4;
    localparam int BIT_MODE = 3;
    localparam int BIT_LEVEL = 2;
    localparam int BIT_ACT_HI = 1;
    localparam int BIT_ACT_LO = 0;
    localparam logic [1:0] ACT_NONE = 2'h0;
    localparam logic [1:0] ACT_CLEAR = 2'h1;
    localparam logic [1:0] ACT_SET = 2'h2;
    localparam logic [1:0] ACT_TOGGLE = 2'h3;
    localparam logic [1:0] EDGE_RISE = 2'h0;
    localparam logic [1:0] EDGE_FALL = 2'h1;
    localparam logic [3:0] FUNC_RESET = 4'h0;
    localparam int CNT_W_DEF = 16;

    // ------------------------------------------------------------
    // Register map of the plain port
    // ------------------------------------------------------------
    localparam int ADDR_W = 4;
    localparam logic [3:0] OFS_CH4_FUNC = 4'h0;
    localparam logic [3:0] OFS_CH5_FUNC = 4'h1;
    localparam logic [3:0] OFS_CH4_REG_A = 4'h2;
    localparam logic [3:0] OFS_CH5_REG_A = 4'h3;
    localparam logic [3:0] OFS_STATUS = 4'h4;
    localparam int ST_CH4_PIN = 0;
    localparam int ST_CH5_PIN = 1;
    localparam int ST_CH4_OE = 2;
    localparam int ST_CH5_OE = 3;
endpackage

/* File: core/tcps_pin_if.sv */
// Interface carrying one channel's decoded pin-function controls.
// Assumes producer and consumer share ref_clk.
interface tcps_pin_if;
    logic compare_mode;
    logic init_level;
    logic [1:0] action;
    logic pin_source;
    logic [1:0] edge_sel;
    modport dec (output compare_mode, init_level, action, pin_source, edge_sel);
    modport use_side (input compare_mode, init_level, action, pin_source, edge_sel);
endinterface

/* File: core/tcps_chan_a.sv */
// One channel's register-A pin unit: compare output and capture.
// Assumes pin_in is already synchronised and match pulses are one cycle.
module tcps_chan_a #(
    parameter int CNT_W = tcps_pkg::CNT_W_DEF,
    parameter bit IS_CH4 = 1'b1
) (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic [3:0] func,
    input wire logic func_wr,
    input wire logic [CNT_W-1:0] counter,
    input wire logic compare_match,
    input wire logic pin_in,
    input wire logic ch3_event,
    input wire logic [CNT_W-1:0] wr_data,
    input wire logic reg_wr,
    tcps_pin_if.dec ctl,
    output logic [CNT_W-1:0] reg_a_reg,
    output logic pin_out_reg,
    output logic pin_oe_reg,
    output logic capture_pulse_reg
);
    logic pin_dly_reg;
    logic rise;
    logic fall;
    logic cap_hit;

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    always_comb begin
        ctl.compare_mode = ~func[tcps_pkg::BIT_MODE];
        ctl.init_level = func[tcps_pkg::BIT_LEVEL];
        ctl.action = func[tcps_pkg::BIT_ACT_HI:tcps_pkg::BIT_ACT_LO];
        // Channel 5 ignores bit 2 in capture; always pin
        ctl.pin_source = IS_CH4 ? ~func[tcps_pkg::BIT_LEVEL] : 1'b1;
        ctl.edge_sel = func[tcps_pkg::BIT_ACT_HI:tcps_pkg::BIT_ACT_LO];
    end

    assign rise = pin_in & ~pin_dly_reg;
    assign fall = ~pin_in & pin_dly_reg;

    always_comb begin
        cap_hit = 1'b0;
        if (!ctl.compare_mode) begin
            if (!ctl.pin_source) begin
                cap_hit = ch3_event;
            end else if (ctl.edge_sel[1]) begin
                cap_hit = rise | fall;
            end else if (ctl.edge_sel == tcps_pkg::EDGE_FALL) begin
                cap_hit = fall;
            end else begin
                cap_hit = rise;
            end
        end
    end

    // ------------------------------------------------------------
    // Edge history
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            pin_dly_reg <= 1'b0;
        end else begin
            pin_dly_reg <= pin_in;
        end
    end

    // ------------------------------------------------------------
    // Capture register; capture beats a software write
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            reg_a_reg <= '0;
            capture_pulse_reg <= 1'b0;
        end else begin
            capture_pulse_reg <= cap_hit;
            if (cap_hit) begin
                reg_a_reg <= counter;
            end else if (reg_wr) begin
                reg_a_reg <= wr_data;
            end
        end
    end

    // ------------------------------------------------------------
    // Pin output
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            pin_out_reg <= 1'b0;
            pin_oe_reg <= 1'b0;
        end else if (!ctl.compare_mode || ctl.action == tcps_pkg::ACT_NONE) begin
            pin_oe_reg <= 1'b0;
        end else if (func_wr) begin
            // Initial level applied on the cycle after the write strobe, held until a match
            pin_oe_reg <= 1'b1;
            pin_out_reg <= ctl.init_level;
        end else begin
            pin_oe_reg <= 1'b1;
            if (compare_match) begin
                unique case (ctl.action)
                    tcps_pkg::ACT_CLEAR: pin_out_reg <= 1'b0;
                    tcps_pkg::ACT_SET: pin_out_reg <= 1'b1;
                    tcps_pkg::ACT_TOGGLE: pin_out_reg <= ~pin_out_reg;
                    default: pin_out_reg <= pin_out_reg;
                endcase
            end
        end
    end
endmodule // tcps_chan_a

/* File: verif/tcps_far_model.sv */
// Far-side model: outside drivers of both timer pins and the ch3 event.
// Assumes the bench calls its tasks from code timed on ref_clk.
module tcps_far_model (
    input wire logic ref_clk,
    input wire logic [1:0] out,
    input wire logic [1:0] oe,
    output logic [1:0] pin_in,
    output logic ch3_event
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] lvl_reg = 2'h0;
    // Block wins while it drives; the outside source is seen only otherwise
    assign pin_in = (oe & out) | (~oe & lvl_reg);
    initial ch3_event = 1'b0;
    task automatic drive(input int ch, input logic v);
        @(posedge ref_clk);
        lvl_reg[ch] <= v;
    endtask
    // One-cycle event, as a ch3 match or capture would give
    task automatic pulse3();
        @(posedge ref_clk);
        ch3_event <= 1'b1;
        @(posedge ref_clk);
        ch3_event <= 1'b0;
    endtask
endmodule // tcps_far_model

/* File: verif/tcps_top_asserts.sv */
// Checker for the ch4 register-A pin function of tcps_top.
// Assumes it is bound to tcps_top and sees its ports only.
module tcps_chk (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic [tcps_pkg::ADDR_W-1:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [31:0] rdata,
    input wire logic ch4_match,
    input wire logic ch3_reg_a_event,
    input wire logic ch4_timer_pin_a_out,
    input wire logic ch4_timer_pin_a_oe,
    input wire logic ch4_capture
);
    // ----------------------------------------
    // Shadow of the ch4 field
    // ----------------------------------------
    logic [3:0] f4_reg;
    logic wr4_reg;
    logic wr4;
    assign wr4 = wr_en && addr == tcps_pkg::OFS_CH4_FUNC;
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            f4_reg <= 4'h0;
            wr4_reg <= 1'b0;
        end else begin
            wr4_reg <= wr4;
            if (wr4) begin
                f4_reg <= wdata[3:0];
            end
        end
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!arst_n);
    // Settled compare field, so a match is not lost to a pending write
    sequence cmp_s(logic [1:0] act);
        !wr4 && !wr4_reg && !f4_reg[3] && f4_reg[1:0] == act && ch4_match;
    endsequence
    chk_init_level: assert property (wr4 && !wdata[3] && wdata[1:0] != 2'h0 |-> ##2
        ch4_timer_pin_a_oe && ch4_timer_pin_a_out == $past(wdata[2], 2))
        else $error("initial level wrong");
    chk_output_off: assert property (wr4 && (wdata[3] || wdata[1:0] == 2'h0) |-> ##2
        !ch4_timer_pin_a_oe) else $error("pin driven when disabled");
    chk_clear_match: assert property (cmp_s(2'h1) |=> !ch4_timer_pin_a_out)
        else $error("match did not drive 0");
    chk_set_match: assert property (cmp_s(2'h2) |=> ch4_timer_pin_a_out)
        else $error("match did not drive 1");
    chk_toggle_match: assert property (cmp_s(2'h3) |=>
        ch4_timer_pin_a_out != $past(ch4_timer_pin_a_out)) else $error("no toggle");
    chk_hold_level: assert property (!wr4 && !wr4_reg && !f4_reg[3] && !ch4_match |=>
        $stable(ch4_timer_pin_a_out)) else $error("pin moved without match");
    chk_ch3_capture: assert property (f4_reg[3:2] == 2'h3 && !wr4 && ch3_reg_a_event |=>
        ch4_capture) else $error("ch3 event not captured");
    chk_read_idle: assert property (!rd_en |=> rdata == 32'h0)
        else $error("read data outside its cycle");
endmodule // tcps_chk

bind tcps_top tcps_chk chk_u (
    .ref_clk(ref_clk), .arst_n(arst_n), .addr(addr), .wdata(wdata),
    .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .ch4_match(ch4_match),
    .ch3_reg_a_event(ch3_reg_a_event), .ch4_timer_pin_a_out(ch4_timer_pin_a_out),
    .ch4_timer_pin_a_oe(ch4_timer_pin_a_oe), .ch4_capture(ch4_capture)
);

/* File: verif/tb.sv */
// Self-checking bench for tcps_top.
// Assumes tcps_far_model drives the pins and the ch3 event.
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    // Row layout: ch, edges counted on rise, on fall, spare, field code
    typedef struct packed {logic ch; logic r; logic f; logic pad; logic [3:0] code;} tcps_row_t;
    tcps_row_t rows [9] = '{8'h48, 8'h29, 8'h6A, 8'h6B, 8'h0C, 8'hC8, 8'hA9, 8'hEE, 8'hCC};
    logic ref_clk = 1'b0;
    logic arst_n = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [31:0] wdata = 32'h0;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    logic [15:0] cnt = 16'h0;
    logic [15:0] counter4 = 16'h0;
    logic [1:0] mt = 2'h0;
    logic [31:0] rdata, d, nseen;
    logic [1:0] pin_in, pin_out, pin_oe, cap;
    logic [3:0] fo, ao;
    logic ch3_ev, lvl;
    int ch;
    int err_count = 0;
    int n_compared = 0;
    int cycles = 0;
    always #5 ref_clk = ~ref_clk;
    tcps_top dut_u (
        .ref_clk(ref_clk), .arst_n(arst_n), .addr(addr), .wdata(wdata), .wr_en(wr_en),
        .rd_en(rd_en), .rdata(rdata), .counter4(counter4), .counter5(cnt),
        .ch4_match(mt[0]), .ch5_match(mt[1]), .ch3_reg_a_event(ch3_ev),
        .ch4_timer_pin_a_in(pin_in[0]), .ch4_timer_pin_a_out(pin_out[0]),
        .ch4_timer_pin_a_oe(pin_oe[0]), .ch5_timer_pin_a_in(pin_in[1]),
        .ch5_timer_pin_a_out(pin_out[1]), .ch5_timer_pin_a_oe(pin_oe[1]),
        .ch4_capture(cap[0]), .ch5_capture(cap[1])
    );
    tcps_far_model fm_u (
        .ref_clk(ref_clk), .out(pin_out), .oe(pin_oe), .pin_in(pin_in), .ch3_event(ch3_ev)
    );
    // ----------------------------------------
    // Bus and check tasks
    // ----------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] v);
        @(posedge ref_clk);
        wr_en <= 1'b1;
        addr <= a;
        wdata <= v;
        @(posedge ref_clk);
        wr_en <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [31:0] v);
        @(posedge ref_clk);
        rd_en <= 1'b1;
        addr <= a;
        @(posedge ref_clk);
        rd_en <= 1'b0;
        #1 v = rdata;
    endtask
    task automatic pulse_match(input int c);
        @(posedge ref_clk);
        mt[c] <= 1'b1;
        @(posedge ref_clk);
        mt <= 2'h0;
        #1;
    endtask
    task automatic wrap_up();
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // Ceiling well above the roughly 560 cycles the tests need
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 6000) begin
            err_count++;
            wrap_up();
        end
    end
    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial begin
        repeat (3) @(posedge ref_clk);
        arst_n <= 1'b1;
        #1 chk({26'h0, pin_oe, pin_out, cap}, 32'h0);
        rd(tcps_pkg::OFS_STATUS, d);
        chk(d, 32'h0);
        foreach (rows[i]) begin
            ch = rows[i].ch;
            fo = tcps_pkg::OFS_CH4_FUNC + 4'(ch);
            ao = tcps_pkg::OFS_CH4_REG_A + 4'(ch);
            fm_u.drive(ch, 1'b0);
            wr(fo, {28'h0, rows[i].code});
            repeat (10) @(posedge ref_clk);
            // Non-zero seed, so a missing capture cannot pass as a reset value
            wr(ao, 32'h5A5A);
            cnt <= 16'hA500 + 16'(i);
            counter4 <= 16'hA500 + 16'(i);
            for (int e = 0; e < 2; e++) begin
                nseen = 0;
                fm_u.drive(ch, e == 0);
                repeat (12) begin
                    @(posedge ref_clk);
                    #1 nseen += {31'h0, cap[ch]};
                end
                chk(nseen, {31'h0, e ? rows[i].f : rows[i].r});
            end
            rd(ao, d);
            chk(d, (rows[i].r || rows[i].f) ? {16'h0, cnt} : 32'h5A5A);
        end
        $display("capture rows done");
        for (int k = 0; k < 16; k++) begin
            ch = k / 8;
            wr(tcps_pkg::OFS_CH4_FUNC + 4'(ch), {29'h0, k[2:0]});
            @(posedge ref_clk);
            #1 chk(pin_oe[ch], k[1:0] != 2'h0);
            lvl = k[2];
            if (k[1:0] != 2'h0) chk(pin_out[ch], lvl);
            repeat (2) begin
                pulse_match(ch);
                lvl = k[1] ? (k[0] ? !lvl : 1'b1) : (k[0] ? 1'b0 : lvl);
                if (k[1:0] != 2'h0) chk(pin_out[ch], lvl);
            end
        end
        // A match in the cycle right after the write must not disturb the start level;
        // set-on-match code, so an applied match would show as a 1
        wr(tcps_pkg::OFS_CH4_FUNC, 32'h2);
        mt[0] <= 1'b1;
        @(posedge ref_clk);
        mt <= 2'h0;
        #1 chk(pin_out[0], 1'b0);
        rd(tcps_pkg::OFS_STATUS, d);
        chk(d, 32'hE);
        $display("compare codes done");
        wr(tcps_pkg::OFS_CH4_FUNC, 32'h8);
        wr(tcps_pkg::OFS_CH5_FUNC, 32'hC);
        repeat (10) @(posedge ref_clk);
        fm_u.pulse3();
        #1 chk(cap, 2'h0);
        wr(tcps_pkg::OFS_CH4_FUNC, 32'hF);
        repeat (10) @(posedge ref_clk);
        counter4 <= 16'h1234;
        fm_u.pulse3();
        counter4 <= 16'h5678;
        #1 chk(cap[0], 1'b1);
        rd(tcps_pkg::OFS_CH4_REG_A, d);
        chk(d, 32'h1234);
        wr(4'h5, 32'hF);
        rd(4'h5, d);
        chk(d, 32'h0);
        $display("ch3 source and unmapped done");
        // A driving pin must be off once a mid-run reset has been applied and released
        wr(tcps_pkg::OFS_CH4_FUNC, 32'h5);
        repeat (2) @(posedge ref_clk);
        #1 chk({30'h0, pin_oe[0], pin_out[0]}, 32'h3);
        @(posedge ref_clk);
        arst_n <= 1'b0;
        repeat (3) @(posedge ref_clk);
        arst_n <= 1'b1;
        rd(tcps_pkg::OFS_CH4_FUNC, d);
        chk(d, 32'h0);
        chk({28'h0, pin_oe, pin_out}, 32'h0);
        rd(tcps_pkg::OFS_CH4_REG_A, d);
        chk(d, 32'h0);
        $display("mid-run reset done");
        wrap_up();
    end
endmodule // tb
